// >>> adc_ctrl_pkg.sv
// Package with register layout, reset values and timing for the converter control block.
package adc_ctrl_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CTRL_ADDR   = 8'hE8;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam int         BIT_ENABLE  = 7;
    localparam int         BIT_BURST   = 6;
    localparam int         BIT_DONE    = 5;
    localparam int         BIT_BUSY    = 4;
    localparam int         BIT_WINDOW  = 3;
    localparam int         BIT_LJUST   = 2;
    localparam int         BIT_SRC_HI  = 1;
    localparam int         BIT_SRC_LO  = 0;

    // ****************************************
    // Start sources and timing
    // ****************************************
    localparam logic [1:0] SRC_SOFTWARE = 2'h0;
    localparam logic [1:0] SRC_TIMER3   = 2'h1;
    localparam logic [1:0] SRC_STROBE   = 2'h2;
    localparam logic [1:0] SRC_TIMER2   = 2'h3;
    localparam int         CLK_MHZ      = 10;
    localparam int         CONV_NS      = 1600;
    localparam int         CONV_CYCLES  = (CONV_NS * CLK_MHZ) / 1000;

endpackage

// >>> conv_timer.sv
// Self-timed single conversion sequencer used by the control block.
`timescale 1ns/1ps
module conv_timer
    import adc_ctrl_pkg::*;
#(
    parameter int CYCLES = CONV_CYCLES
) (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Start and finish.
    input  wire logic start,
    output logic      running,
    output logic      finished
);

    logic [15:0] count_q;
    logic [15:0] count_d;

    // Load on start, count down, pulse finished at one.
    assign count_d  = start ? 16'(CYCLES) : (count_q != 16'h0000 ? count_q - 16'h0001 : 16'h0000);
    assign running  = (count_q != 16'h0000);
    assign finished = (count_q == 16'h0001);

    // Counter register.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 16'h0000;
        end else begin
            count_q <= count_d;
        end
    end

endmodule

// >>> adc_conversion_control.sv
// Control register, trigger selection and sequencing of the converter; repeat is tied to one conversion, so burst never chains.
`timescale 1ns/1ps
module adc_conversion_control
    import adc_ctrl_pkg::*;
(
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Special-function register port.
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    output logic [7:0]      sfr_rdata,
    // Trigger sources.
    input  wire logic       timer3_overflow,
    input  wire logic       timer2_overflow,
    input  wire logic       external_convert_strobe,
    // Window comparator event from the analog side.
    input  wire logic       window_hit,
    // Outputs to the converter and processor.
    output logic            converter_enable,
    output logic            sample_pulse,
    output logic            conversion_irq
);

    // ****************************************
    // Register fields
    // ****************************************
    logic       burst_enable_q;
    logic       conversion_done_flag_q;
    logic       window_compare_flag_q;
    logic       left_justify_select_q;
    logic [1:0] start_source_select_q;
    logic       enable_q;
    logic       conversion_busy_q;
    logic       busy_prev_q;
    logic [4:0] remain_q;
    logic       window_seen_q;
    logic [2:0] strobe_sync_q;

    // Sequence control wires.
    logic       ctrl_wr;
    logic       trigger;
    logic       conv_start;
    logic       conv_running;
    logic       conv_finished;
    logic       last_conv;
    logic       busy_fall;
    logic       manual_next;
    logic [4:0] repeat_total;

    // Repeat field decode: 00->1, 01->4, 10->8, 11->16.
    function automatic logic [4:0] repeat_decode(input logic [1:0] rpt);
        unique case (rpt)
            2'b00: repeat_decode = 5'd1;
            2'b01: repeat_decode = 5'd4;
            2'b10: repeat_decode = 5'd8;
            2'b11: repeat_decode = 5'd16;
        endcase
    endfunction

    // ****************************************
    // Trigger selection
    // ****************************************
    // The repeat field lives outside this register, so the count is tied to one conversion.
    // A user who needs accumulation must widen this tie-off into a configuration input.
    logic [1:0] repeat_count;
    assign repeat_count = 2'b00;
    assign repeat_total = repeat_decode(repeat_count);

    assign ctrl_wr = sfr_wr && (sfr_addr == CTRL_ADDR);
    assign trigger = enable_q && (
        (start_source_select_q == SRC_SOFTWARE && ctrl_wr && sfr_wdata[BIT_BUSY]) ||
        (start_source_select_q == SRC_TIMER3   && timer3_overflow) ||
        (start_source_select_q == SRC_STROBE   && strobe_sync_q[1] && !strobe_sync_q[2]) ||
        (start_source_select_q == SRC_TIMER2   && timer2_overflow));
    assign last_conv   = (remain_q <= 5'd1);
    // Without burst, every further repeat waits for its own trigger once the timer is idle.
    assign manual_next = trigger && conversion_busy_q && !conv_running && !burst_enable_q;
    assign conv_start  = (trigger && !conversion_busy_q) || manual_next ||
                         (conv_finished && !last_conv && burst_enable_q);
    // Busy falling edge, seen one cycle late, sets the completion flag.
    assign busy_fall   = busy_prev_q && !conversion_busy_q;

    conv_timer u_timer (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .start    (conv_start),
        .running  (conv_running),
        .finished (conv_finished)
    );

    // Strobe synchroniser; bits 1 and 2 feed the edge detector.
    // Reset clears every stage to the idle low level, so no false edge follows reset.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_sync_q <= 3'b000;
        end else begin
            strobe_sync_q <= {strobe_sync_q[1:0], external_convert_strobe};
        end
    end

    // ****************************************
    // Busy and repeat sequencing
    // ****************************************
    // repeat accumulation count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_busy_q <= 1'b0;
            busy_prev_q       <= 1'b0;
            remain_q          <= 5'd0;
            window_seen_q     <= 1'b0;
        end else begin
            busy_prev_q <= conversion_busy_q;
            if (trigger && !conversion_busy_q) begin
                conversion_busy_q <= 1'b1;
                remain_q          <= repeat_total;
                window_seen_q     <= 1'b0;
            end else if (conv_finished) begin
                remain_q <= remain_q - 5'd1;
                window_seen_q <= window_seen_q | window_hit;
                if (last_conv) begin
                    conversion_busy_q <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    // Software writes the fields; a hardware set of a flag beats a software clear.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q               <= CTRL_RESET[BIT_ENABLE];
            burst_enable_q         <= CTRL_RESET[BIT_BURST];
            conversion_done_flag_q <= CTRL_RESET[BIT_DONE];
            window_compare_flag_q  <= CTRL_RESET[BIT_WINDOW];
            left_justify_select_q  <= CTRL_RESET[BIT_LJUST];
            start_source_select_q  <= CTRL_RESET[BIT_SRC_HI:BIT_SRC_LO];
        end else begin
            if (ctrl_wr) begin
                enable_q              <= sfr_wdata[BIT_ENABLE];
                burst_enable_q        <= sfr_wdata[BIT_BURST];
                left_justify_select_q <= sfr_wdata[BIT_LJUST];
                start_source_select_q <= sfr_wdata[BIT_SRC_HI:BIT_SRC_LO];
            end
            conversion_done_flag_q <= busy_fall ||
                (ctrl_wr ? sfr_wdata[BIT_DONE] : conversion_done_flag_q);
            window_compare_flag_q  <= (busy_fall && window_seen_q) ||
                (ctrl_wr ? sfr_wdata[BIT_WINDOW] : window_compare_flag_q);
        end
    end

    // Read data and outputs.
    assign sfr_rdata = (sfr_addr == CTRL_ADDR) ?
        {enable_q, burst_enable_q, conversion_done_flag_q, conversion_busy_q,
         window_compare_flag_q, left_justify_select_q, start_source_select_q} : 8'h00;
    assign converter_enable = enable_q;
    assign sample_pulse     = conv_start;
    assign conversion_irq   = conversion_done_flag_q;

    // ****************************************
    // Assertions
    // ****************************************
    // Completion flag and interrupt request.
    AST_DONE_ON_FALL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(conversion_busy_q) |=> conversion_done_flag_q) else $error("done not set");
    AST_DONE_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        conversion_done_flag_q && !ctrl_wr |=> conversion_done_flag_q) else $error("done lost");
    AST_DONE_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctrl_wr && !sfr_wdata[BIT_DONE] && !busy_fall |=> !conversion_done_flag_q)
        else $error("done not cleared");
    AST_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        busy_fall |=> conversion_irq) else $error("irq not raised");

    // Busy indication and software starts.
    AST_SW_START: assert property (@(posedge ref_clk) disable iff (!rst_n)
        enable_q && start_source_select_q == SRC_SOFTWARE && ctrl_wr && sfr_wdata[BIT_BUSY]
        && !conversion_busy_q |=> conversion_busy_q) else $error("no sw start");
    AST_WRITE_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        enable_q && start_source_select_q == SRC_SOFTWARE && !conversion_busy_q
        && !(ctrl_wr && sfr_wdata[BIT_BUSY]) |=> !conversion_busy_q)
        else $error("stray start");
    AST_BUSY_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        conv_running && sfr_addr == CTRL_ADDR |-> sfr_rdata[BIT_BUSY]) else $error("busy");

    // Trigger sources.
    AST_T3: assert property (@(posedge ref_clk) disable iff (!rst_n)
        enable_q && start_source_select_q == SRC_TIMER3 && timer3_overflow && !conversion_busy_q
        |=> conversion_busy_q) else $error("timer3 start lost");
    AST_T2: assert property (@(posedge ref_clk) disable iff (!rst_n)
        enable_q && start_source_select_q == SRC_TIMER2 && timer2_overflow && !conversion_busy_q
        |=> conversion_busy_q) else $error("timer2 start lost");
    AST_STROBE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        enable_q && start_source_select_q == SRC_STROBE && strobe_sync_q[1] && !strobe_sync_q[2]
        && !conversion_busy_q |=> conversion_busy_q) else $error("strobe start lost");
    AST_DISABLED: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !enable_q && !conversion_busy_q |-> !sample_pulse) else $error("start while disabled");

    // Repeat and burst sequencing.
    AST_SINGLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        conv_finished && remain_q == 5'd1 |=> !conversion_busy_q) else $error("repeat");
    AST_BURST: assert property (@(posedge ref_clk) disable iff (!rst_n)
        conv_finished && !last_conv && burst_enable_q |-> sample_pulse) else $error("burst");
    AST_NO_RESTART: assert property (@(posedge ref_clk) disable iff (!rst_n)
        conv_running && !conv_finished |-> !sample_pulse) else $error("start while running");

    // Main scenarios that the tests should reach.
    COV_DONE: cover property (@(posedge ref_clk) disable iff (!rst_n) busy_fall);
    COV_STROBE: cover property (@(posedge ref_clk) disable iff (!rst_n)
        start_source_select_q == SRC_STROBE && trigger);
    COV_CLEAR: cover property (@(posedge ref_clk) disable iff (!rst_n)
        conversion_done_flag_q ##1 !conversion_done_flag_q);
    COV_TIMER2: cover property (@(posedge ref_clk) disable iff (!rst_n)
        start_source_select_q == SRC_TIMER2 && trigger);
    COV_WINDOW: cover property (@(posedge ref_clk) disable iff (!rst_n)
        busy_fall && window_seen_q);

endmodule

// >>> adc_conversion_control_bench.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
module adc_conversion_control_bench
    import adc_ctrl_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    logic        ref_clk, rst_n, sfr_wr, window_hit;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
    logic        timer3_overflow, timer2_overflow, external_convert_strobe;
    logic        converter_enable, sample_pulse, conversion_irq;
    int          miscompares, cmp_count, n, i, s;
    logic [15:0] rows [5] = '{16'h8484, 16'h8383, 16'hC1C1, 16'h1000, 16'h8080};

    adc_conversion_control adc_conversion_control_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .timer3_overflow(timer3_overflow),
        .timer2_overflow(timer2_overflow), .external_convert_strobe(external_convert_strobe),
        .window_hit(window_hit), .converter_enable(converter_enable),
        .sample_pulse(sample_pulse), .conversion_irq(conversion_irq));

    // ****************************************
    // Tasks
    // ****************************************
    // Compares one byte and counts the result.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Writes the control register and checks the start pulse in the write cycle.
    // One idle cycle follows, so back-to-back writes never re-raise the strobe at once.
    task automatic wr(input logic [7:0] d, input logic sp);
        sfr_wdata = d;
        sfr_wr = 1'b1;
        #1 chk({7'h00, sample_pulse}, {7'h00, sp});
        @(negedge ref_clk);
        sfr_wr = 1'b0;
        @(negedge ref_clk);
    endtask

    // Fires one trigger source for one cycle: 1 timer 3, 2 strobe, 3 timer 2.
    task automatic pulse(input int src);
        timer3_overflow = (src == 1);
        external_convert_strobe = (src == 2);
        timer2_overflow = (src == 3);
        @(negedge ref_clk);
        {timer3_overflow, external_convert_strobe, timer2_overflow} = 3'h0;
    endtask

    // Counts busy cycles, then checks the register and the interrupt request.
    task automatic conv(input int exp_n, input logic [7:0] done_exp);
        n = 0;
        for (int k = 0; k < 8 && sfr_rdata[BIT_BUSY] !== 1'b1; k++) @(negedge ref_clk);
        while (sfr_rdata[BIT_BUSY] === 1'b1 && n < 40) begin
            n++;
            @(negedge ref_clk);
        end
        chk(8'(n), 8'(exp_n));
        @(negedge ref_clk);
        chk(sfr_rdata, done_exp);
        chk({7'h00, conversion_irq}, 8'h01);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    // Makes the 100 ns clock.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Cuts a hang short well after all tests should be over.
    initial begin
        repeat (3000) @(posedge ref_clk);
        miscompares++;
        $display("watchdog expired");
        complete_run();
    end

    // Runs reset, the table rows and the hand-written cases.
    initial begin
        {rst_n, sfr_wr, window_hit, timer3_overflow, timer2_overflow} = 5'h00;
        external_convert_strobe = 1'b0;
        sfr_wdata = 8'h00;
        sfr_addr = CTRL_ADDR;
        miscompares = 0;
        cmp_count = 0;
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        chk(sfr_rdata, CTRL_RESET);
        chk({5'h00, converter_enable, sample_pulse, conversion_irq}, 8'h00);
        sfr_addr = 8'hE9;
        #1 chk(sfr_rdata, 8'h00);
        @(negedge ref_clk);
        sfr_addr = CTRL_ADDR;
        $display("test reset done");
        for (i = 0; i < 5; i++) begin
            wr(rows[i][15:8], 1'b0);
            chk(sfr_rdata, rows[i][7:0]);
            chk({7'h00, converter_enable}, {7'h00, rows[i][15]});
        end
        $display("test table done");
        window_hit = 1'b1;
        wr(8'h90, 1'b1);
        repeat (3) @(negedge ref_clk);
        wr(8'h90, 1'b0);
        conv(10, 8'hA8);
        repeat (10) @(negedge ref_clk);
        chk(sfr_rdata, 8'hA8);
        window_hit = 1'b0;
        wr(8'h80, 1'b0);
        chk(sfr_rdata, 8'h80);
        $display("test software start done");
        // A clear written in the very cycle in which the flag is set must lose.
        wr(8'h90, 1'b1);
        repeat (15) @(negedge ref_clk);
        wr(8'h80, 1'b0);
        chk(sfr_rdata, 8'hA0);
        chk({7'h00, conversion_irq}, 8'h01);
        wr(8'h80, 1'b0);
        chk(sfr_rdata, 8'h80);
        $display("test set beats clear done");
        for (s = 1; s < 4; s++) begin
            wr(8'h80 | 8'(s), 1'b0);
            pulse((s % 3) + 1);
            wr(8'h90 | 8'(s), 1'b0);
            repeat (4) @(negedge ref_clk);
            chk(sfr_rdata, 8'h80 | 8'(s));
            pulse(s);
            conv(CONV_CYCLES, 8'hA0 | 8'(s));
            wr(8'h80, 1'b0);
        end
        $display("test sources done");
        wr(8'hD0, 1'b1);
        conv(CONV_CYCLES - 1, 8'hE0);
        wr(8'h80, 1'b0);
        $display("test burst done");
        wr(8'h90, 1'b1);
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b0;
        #1 chk(sfr_rdata, CTRL_RESET);
        chk({5'h00, converter_enable, sample_pulse, conversion_irq}, 8'h00);
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(sfr_rdata, CTRL_RESET);
        wr(8'h80, 1'b0);
        wr(8'h90, 1'b1);
        conv(CONV_CYCLES - 1, 8'hA0);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
